// [verilog/dia_pkg.sv]
package dia_pkg;
  localparam int ADDR_W = 9;
  localparam int BANKS  = 4;
  localparam int PIN_W  = 30;
  // Sampler image after reset: row, column and write strobes, selects, refresh mode bit and request idle high
  localparam logic [PIN_W-1:0] PIN_RST = 30'h0000df9;

  localparam int CLK_PERIOD_NS = 100;
  localparam int ROW_HOLD_NS   = 30;
  localparam int COL_VALID_NS  = 40;
  localparam int COLUMN_STROBE_IN_CAS_NS  = 40;
  localparam int CAS_AUTO_NS   = 20;
  // Least time rounds up
  localparam int ROW_HOLD_CYC =
    (ROW_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Longest times round down, but never below one cycle
  localparam int COL_VALID_CYC = (COL_VALID_NS < CLK_PERIOD_NS) ? 1 :
    COL_VALID_NS / CLK_PERIOD_NS;
  localparam int COLUMN_STROBE_IN_CAS_CYC = (COLUMN_STROBE_IN_CAS_NS < CLK_PERIOD_NS) ? 1 :
    COLUMN_STROBE_IN_CAS_NS / CLK_PERIOD_NS;
  localparam int CAS_AUTO_CYC = (CAS_AUTO_NS < CLK_PERIOD_NS) ? 1 :
    CAS_AUTO_NS / CLK_PERIOD_NS;

  localparam logic [2:0] MODE_ALLBANK = 3'h3;
  localparam logic [2:0] MODE_EXT     = 3'h4;
  localparam logic [2:0] MODE_AUTO    = 3'h5;
  localparam logic [2:0] MODE_FORCED  = 3'h1;
  localparam logic [2:0] MODE_EOC     = 3'h7;

  localparam logic [1:0] EOC_SEL_RST = 2'h3;
  localparam logic [1:0] EOC_SEL_EXT = 2'h3;
  localparam logic [8:0] EOC_127     = 9'h07f;
  localparam logic [8:0] EOC_255     = 9'h0ff;
  localparam logic [8:0] EOC_511     = 9'h1ff;
  localparam logic [8:0] CNT_RST     = 9'h000;
  localparam logic [2:0] TMR_MAX     = 3'h7;

  typedef enum logic [1:0] {
    PH_PRE = 2'b00,
    PH_ROW = 2'b01,
    PH_COL = 2'b10,
    PH_END = 2'b11
  } dia_phase_type;

  typedef enum logic [2:0] {
    FR_IDLE = 3'b000,
    FR_REQ  = 3'b001,
    FR_SYNC = 3'b010,
    FR_RAS1 = 3'b011,
    FR_RAS2 = 3'b100,
    FR_DONE = 3'b101
  } dia_forced_type;
endpackage

// [verilog/dia_sync.sv]
`timescale 1ns/1ps
module dia_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_sys,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
        meta_q[i]   <= RST_VAL[i];
        sync_out[i] <= RST_VAL[i];
      end else begin
        meta_q[i]   <= async_in[i];
        sync_out[i] <= meta_q[i];
      end
    end
  end
endmodule

// [verilog/dia_rfcnt.sv]
`timescale 1ns/1ps
module dia_rfcnt #(
  parameter int CNT_W = dia_pkg::ADDR_W
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic             eoc_load,
  input  wire logic [1:0]       eoc_sel_in,
  input  wire logic             clear,
  input  wire logic             advance,
  output logic      [CNT_W-1:0] count,
  output logic      [1:0]       eoc_sel,
  output logic                  at_eoc
);
  import dia_pkg::*;
  logic [CNT_W-1:0] eoc_val;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) eoc_sel <= EOC_SEL_RST;
    else if (eoc_load) eoc_sel <= eoc_sel_in;
  end

  always_comb begin
    case (eoc_sel)
      2'h1:       eoc_val = CNT_W'(EOC_255);
      2'h2:       eoc_val = CNT_W'(EOC_511);
      default:    eoc_val = CNT_W'(EOC_127);
    endcase
  end

  assign at_eoc = (count == eoc_val);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) count <= CNT_W'(CNT_RST);
    else if (clear) count <= CNT_W'(CNT_RST);
    else if (advance) begin
      if (at_eoc) count <= CNT_W'(CNT_RST);
      else count <= count + CNT_W'(1);
    end
  end

  property p_wrap;
    @(posedge clk_sys) disable iff (!reset_n)
    at_eoc && advance && !clear |=> count == '0 && !at_eoc;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("refresh counter did not wrap after end of count");
endmodule

// [verilog/dia_ctrl.sv]
`timescale 1ns/1ps
module dia_ctrl (
  input  wire logic                       clk_sys,
  input  wire logic                       reset_n,
  input  wire logic [dia_pkg::ADDR_W-1:0] row_addr_in,
  input  wire logic [dia_pkg::ADDR_W-1:0] col_addr_in,
  input  wire logic                       bank_select_high,
  input  wire logic                       bank_select_low,
  input  wire logic                       address_latch_strobe,
  input  wire logic                       chip_select_n,
  input  wire logic                       row_col_select,
  input  wire logic                       row_strobe_in_n,
  input  wire logic                       column_strobe_in_n,
  input  wire logic                       write_enable_in_n,
  input  wire logic                       refresh_mode_bit,
  input  wire logic [1:0]                 mode_select_low,
  input  wire logic                       refresh_request_pin_in,
  output logic      [dia_pkg::ADDR_W-1:0] muxed_address_out,
  output logic                            muxed_address_oe_n,
  output logic      [dia_pkg::BANKS-1:0]  row_strobe_out_n,
  output logic                            column_strobe_out_n,
  output logic                            write_enable_out_n,
  output logic                            refresh_request_pin_out,
  output logic                            refresh_request_pin_oe_n
);
  import dia_pkg::*;

  logic [PIN_W-1:0]  pins_s;
  logic [ADDR_W-1:0] row_s;
  logic [ADDR_W-1:0] col_s;
  logic              bsel_hi_s;
  logic              bsel_lo_s;
  logic              ads_s;
  logic              cs_n_s;
  logic              rc_s;
  logic              ras_n_s;
  logic              cas_n_s;
  logic              we_n_s;
  logic              m2_s;
  logic [1:0]        ml_s;
  logic              rf_in_s;

  // Every pin is asynchronous to clk_sys, so all pass the sampler
  dia_sync #(
    .W       (PIN_W),
    .RST_VAL (PIN_RST)
  ) u_sync (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .async_in ({row_addr_in, col_addr_in, bank_select_high,
                bank_select_low, address_latch_strobe, chip_select_n,
                row_col_select, row_strobe_in_n, column_strobe_in_n,
                write_enable_in_n, refresh_mode_bit, mode_select_low,
                refresh_request_pin_in}),
    .sync_out (pins_s)
  );

  assign {row_s, col_s, bsel_hi_s, bsel_lo_s, ads_s, cs_n_s, rc_s,
          ras_n_s, cas_n_s, we_n_s, m2_s, ml_s, rf_in_s} = pins_s;

  logic ras_p_q;
  logic rc_p_q;
  logic cas_p_q;
  logic ads_p_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ras_p_q <= 1'b1;
      rc_p_q  <= 1'b1;
      cas_p_q <= 1'b1;
      ads_p_q <= 1'b0;
    end else begin
      ras_p_q <= ras_n_s;
      rc_p_q  <= rc_s;
      cas_p_q <= cas_n_s;
      ads_p_q <= ads_s;
    end
  end

  logic [2:0] mode_w;
  logic       is_3a;
  logic       is_3b;
  logic       is_4;
  logic       is_auto;
  logic       is_7;
  logic       ras_fell;
  logic       ras_rose;
  logic       refresh_period_clock_rise;
  logic       refresh_period_clock_fall;
  logic       strobe_generator_clock_fall;

  logic [ADDR_W-1:0] cnt;
  logic [1:0]        eoc_sel;
  logic              at_eoc;

  assign mode_w    = {m2_s, ml_s};
  assign is_3a     = (mode_w == MODE_ALLBANK) && (eoc_sel != EOC_SEL_EXT);
  assign is_3b     = (mode_w == MODE_ALLBANK) && (eoc_sel == EOC_SEL_EXT);
  assign is_4      = (mode_w == MODE_EXT);
  assign is_auto   = (mode_w == MODE_AUTO) || (mode_w == MODE_FORCED);
  assign is_7      = (mode_w == MODE_EOC);
  assign ras_fell  = ras_p_q && !ras_n_s;
  assign ras_rose  = !ras_p_q && ras_n_s;
  // Select pin doubles as refresh clock, column input as generator clock
  assign refresh_period_clock_rise = !rc_p_q && rc_s;
  assign refresh_period_clock_fall = rc_p_q && !rc_s;
  assign strobe_generator_clock_fall = cas_p_q && !cas_n_s;

  // Address and bank latches are transparent while the strobe is high, outside MODE_EOC
  logic [ADDR_W-1:0] row_lat_q;
  logic [ADDR_W-1:0] col_lat_q;
  logic [1:0]        bank_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      row_lat_q <= '0;
      col_lat_q <= '0;
      bank_q    <= 2'h0;
    end else if (ads_s && !is_7) begin
      row_lat_q <= row_s;
      col_lat_q <= col_s;
      bank_q    <= {bsel_hi_s, bsel_lo_s};
    end
  end

  // All-bank write sequencer, one step per generator clock fall
  dia_phase_type phase_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) phase_q <= PH_PRE;
    else if (!is_3a) phase_q <= PH_PRE;
    else if (strobe_generator_clock_fall) begin
      unique case (phase_q)
        PH_PRE: phase_q <= PH_ROW;
        PH_ROW: phase_q <= PH_COL;
        PH_COL: phase_q <= PH_END;
        PH_END: phase_q <= PH_PRE;
      endcase
    end
  end

  // Forced refresh handshake and hidden refresh tracking
  dia_forced_type fr_q;
  logic           req_q;
  logic           hid_q;
  logic           hid_start;
  logic           fr_start;
  logic           fr_ras;

  assign hid_start = is_auto && (fr_q == FR_IDLE) && !hid_q && cs_n_s &&
                     rc_s && req_q && ras_fell;
  assign fr_start  = (fr_q == FR_SYNC) && strobe_generator_clock_fall;
  assign fr_ras    = (fr_q == FR_RAS1) || (fr_q == FR_RAS2);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) req_q <= 1'b0;
    else if (is_auto && refresh_period_clock_rise) req_q <= 1'b1;
    else if (hid_start || fr_start) req_q <= 1'b0;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) hid_q <= 1'b0;
    else if (hid_start) hid_q <= 1'b1;
    else if (ras_rose) hid_q <= 1'b0;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) fr_q <= FR_IDLE;
    else if (!is_auto) fr_q <= FR_IDLE;
    else begin
      unique case (fr_q)
        FR_IDLE: if (refresh_period_clock_fall && req_q) fr_q <= FR_REQ;
        FR_REQ:  if (mode_w == MODE_FORCED) fr_q <= FR_SYNC;
        FR_SYNC: if (strobe_generator_clock_fall) fr_q <= FR_RAS1;
        FR_RAS1: if (strobe_generator_clock_fall) fr_q <= FR_RAS2;
        FR_RAS2: if (strobe_generator_clock_fall) fr_q <= FR_DONE;
        FR_DONE: if (mode_w != MODE_FORCED) fr_q <= FR_IDLE;
        default: fr_q <= FR_IDLE;
      endcase
    end
  end

  logic advance;
  logic rf_drive;

  assign advance  = (is_3a && strobe_generator_clock_fall && (phase_q == PH_END)) ||
                    (hid_q && ras_rose) ||
                    ((fr_q == FR_RAS2) && strobe_generator_clock_fall);
  assign rf_drive = (is_3a && at_eoc) || (fr_q == FR_REQ) ||
                    (fr_q == FR_SYNC);

  dia_rfcnt #(
    .CNT_W (ADDR_W)
  ) u_rfcnt (
    .clk_sys    (clk_sys),
    .reset_n    (reset_n),
    .eoc_load   (is_7 && ads_p_q && !ads_s),
    .eoc_sel_in ({bsel_hi_s, bsel_lo_s}),
    .clear      (is_7 && !rf_in_s && refresh_request_pin_oe_n),
    .advance    (advance),
    .count      (cnt),
    .eoc_sel    (eoc_sel),
    .at_eoc     (at_eoc)
  );

  // Column switch and column strobe timing for access modes
  logic [2:0] col_cnt_q;
  logic [2:0] cas_cnt_q;
  logic       early_q;
  logic       colsel_req;
  logic       show_col;
  logic       cas_arm;
  logic       cas_go;
  logic [2:0] switch_at;
  logic [2:0] cas_lag;

  assign colsel_req = is_auto ?
    (!ras_n_s && !cs_n_s && !hid_q && (fr_q == FR_IDLE)) :
    ((is_4 || is_3b) && !rc_s);
  assign switch_at  = is_auto ? 3'(ROW_HOLD_CYC + COL_VALID_CYC - 1) :
                                3'(COL_VALID_CYC - 1);
  assign show_col   = colsel_req && (col_cnt_q >= switch_at);
  assign cas_arm    = show_col && (is_auto || !cas_n_s);
  // Input low at the switch means the strobe follows the address itself
  assign cas_lag    = (is_auto || early_q) ? 3'(CAS_AUTO_CYC) :
                      3'(COLUMN_STROBE_IN_CAS_CYC - 1);
  assign cas_go     = cas_arm && (cas_cnt_q >= cas_lag);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) col_cnt_q <= 3'h0;
    else if (!colsel_req) col_cnt_q <= 3'h0;
    else if (col_cnt_q != TMR_MAX) col_cnt_q <= col_cnt_q + 3'h1;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) cas_cnt_q <= 3'h0;
    else if (!cas_arm) cas_cnt_q <= 3'h0;
    else if (cas_cnt_q != TMR_MAX) cas_cnt_q <= cas_cnt_q + 3'h1;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) early_q <= 1'b0;
    else if (colsel_req && (col_cnt_q == 3'h0)) early_q <= !cas_n_s;
  end

  // Output selection; everything is registered before the pins
  logic [ADDR_W-1:0] addr_d;
  logic              oe_n_d;
  logic [BANKS-1:0]  rows_d;
  logic              cas_d;
  logic              we_d;
  logic [ADDR_W-1:0] acc_addr;
  logic [BANKS-1:0]  bank_rows;

  assign acc_addr  = show_col ? col_lat_q : row_lat_q;
  assign bank_rows = ras_n_s ? {BANKS{1'b1}} :
                     ~(BANKS'(1) << bank_q);

  always_comb begin
    addr_d = muxed_address_out;
    oe_n_d = 1'b1;
    rows_d = {BANKS{1'b1}};
    cas_d  = 1'b1;
    we_d   = 1'b1;
    if (is_3a) begin
      // Select, row strobe and write inputs are ignored in this mode
      oe_n_d = 1'b0;
      addr_d = (phase_q == PH_COL) ? col_s : cnt;
      if ((phase_q == PH_ROW) || (phase_q == PH_COL))
        rows_d = {BANKS{1'b0}};
      cas_d  = (phase_q != PH_COL);
      we_d   = 1'b0;
    end else if (is_3b) begin
      oe_n_d = 1'b0;
      addr_d = acc_addr;
      rows_d = {BANKS{ras_n_s}};
      cas_d  = !cas_go;
      we_d   = we_n_s;
    end else if (is_4) begin
      if (!cs_n_s) begin
        oe_n_d = 1'b0;
        addr_d = acc_addr;
        rows_d = bank_rows;
        cas_d  = !cas_go;
        we_d   = we_n_s;
      end
    end else if (is_auto) begin
      if (fr_q != FR_IDLE) begin
        oe_n_d = 1'b0;
        addr_d = cnt;
        if (fr_ras) rows_d = {BANKS{1'b0}};
      end else if (hid_q || (cs_n_s && rc_s)) begin
        oe_n_d = 1'b0;
        addr_d = cnt;
        rows_d = {BANKS{ras_n_s}};
      end else if (!cs_n_s) begin
        oe_n_d = 1'b0;
        addr_d = acc_addr;
        rows_d = bank_rows;
        cas_d  = !cas_go;
        we_d   = we_n_s;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      muxed_address_out  <= '0;
      muxed_address_oe_n <= 1'b1;
      row_strobe_out_n   <= {BANKS{1'b1}};
      column_strobe_out_n <= 1'b1;
      write_enable_out_n <= 1'b1;
    end else begin
      muxed_address_out  <= addr_d;
      muxed_address_oe_n <= oe_n_d;
      row_strobe_out_n   <= rows_d;
      column_strobe_out_n <= cas_d;
      write_enable_out_n <= we_d;
    end
  end

  // Open-drain request: the pin is only ever pulled low
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      refresh_request_pin_out  <= 1'b0;
      refresh_request_pin_oe_n <= 1'b1;
    end else begin
      refresh_request_pin_out  <= 1'b0;
      refresh_request_pin_oe_n <= !rf_drive;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  property p_allbank_strobe;
    is_3a && (phase_q == PH_COL) |=> row_strobe_out_n == 4'h0 &&
      !column_strobe_out_n && !write_enable_out_n;
  endproperty
  a_allbank_strobe: assert property (p_allbank_strobe)
    else $error("all-bank write did not strobe every bank");

  property p_allbank_we;
    is_3a |=> !write_enable_out_n && !muxed_address_oe_n;
  endproperty
  a_allbank_we: assert property (p_allbank_we)
    else $error("write enable not held low in all-bank write");

  property p_eoc_req;
    is_3a && at_eoc |=> !refresh_request_pin_oe_n;
  endproperty
  a_eoc_req: assert property (p_eoc_req)
    else $error("request pin not low at end of count");

  property p_allbank_period;
    is_3a && (phase_q == PH_END) && strobe_generator_clock_fall |=>
      phase_q == PH_PRE && cnt != $past(cnt);
  endproperty
  a_allbank_period: assert property (p_allbank_period)
    else $error("all-bank write cycle did not close after four steps");

  property p_ext_allrows;
    is_3b |=> row_strobe_out_n == {4{$past(ras_n_s)}};
  endproperty
  a_ext_allrows: assert property (p_ext_allrows)
    else $error("row strobes did not follow input in external write");

  property p_bank_only;
    is_4 && !cs_n_s && !ras_n_s |=> row_strobe_out_n == ~(4'h1 << bank_q);
  endproperty
  a_bank_only: assert property (p_bank_only)
    else $error("wrong row strobe for selected bank");

  property p_hidden_clr;
    hid_start && !refresh_period_clock_rise |=> !req_q && hid_q;
  endproperty
  a_hidden_clr: assert property (p_hidden_clr)
    else $error("hidden refresh did not clear request flag");

  property p_force_req;
    is_auto && refresh_period_clock_fall && req_q && (fr_q == FR_IDLE) && is_auto
      |=> fr_q == FR_REQ;
  endproperty
  a_force_req: assert property (p_force_req)
    else $error("no refresh request after clock fell with flag set");

  property p_ack_only;
    (fr_q == FR_REQ) && (mode_w == MODE_AUTO) |=>
      fr_q == FR_REQ && row_strobe_out_n == 4'hf;
  endproperty
  a_ack_only: assert property (p_ack_only)
    else $error("forced refresh began without acknowledge");

  property p_force_ras;
    is_auto && fr_start ##1 is_auto |=>
      row_strobe_out_n == 4'h0 && refresh_request_pin_oe_n;
  endproperty
  a_force_ras: assert property (p_force_ras)
    else $error("forced strobe or request release misplaced");
endmodule

// [tb/dia_colctr_model.sv]
`timescale 1ns/1ps
module dia_colctr_model (
  input  wire logic       reset_n,
  input  wire logic       enable,
  input  wire logic       advance_pin,
  output logic      [8:0] col_out
);
  logic [8:0] count_q;

  // Steps as the request line is released, so the end-count row still
  // gets its column before the next column starts at row zero
  always_ff @(posedge advance_pin or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= 9'h000;
    end else if (enable) begin
      count_q <= count_q + 9'h001;
    end
  end

  // Released outputs must not look like a held column
  assign col_out = enable ? count_q : ~count_q;
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import dia_pkg::*;
  logic       clk_sys = 1'b0;
  logic       reset_n = 1'b1;
  logic       bank_select_high, bank_select_low, host_pull, ext_en;
  logic       address_latch_strobe, chip_select_n, row_col_select;
  logic       row_strobe_in_n, column_strobe_in_n, write_enable_in_n;
  logic       refresh_mode_bit;
  logic [1:0] mode_select_low;
  logic [8:0] row_addr_in, col_host, ext_col, muxed_address_out;
  wire  [8:0] col_addr_in;
  wire        refresh_request_pin_in;
  logic [3:0] row_strobe_out_n;
  logic       muxed_address_oe_n, column_strobe_out_n, write_enable_out_n;
  logic       refresh_request_pin_out, refresh_request_pin_oe_n;
  int         errors = 0;
  int         checked = 0;
  int         cnt, eoc, n;
  int         col_exp = 0;
  int         eoc_tab[3] = '{127, 255, 511};

  // Open-drain request line with a pull-up
  assign refresh_request_pin_in =
    ((!refresh_request_pin_oe_n && !refresh_request_pin_out) || host_pull)
    ? 1'b0 : 1'b1;
  assign col_addr_in = ext_en ? ext_col : col_host;

  dia_ctrl uut (.clk_sys, .reset_n, .row_addr_in, .col_addr_in,
    .bank_select_high, .bank_select_low, .address_latch_strobe,
    .chip_select_n, .row_col_select, .row_strobe_in_n, .column_strobe_in_n,
    .write_enable_in_n, .refresh_mode_bit, .mode_select_low,
    .refresh_request_pin_in, .muxed_address_out, .muxed_address_oe_n,
    .row_strobe_out_n, .column_strobe_out_n, .write_enable_out_n,
    .refresh_request_pin_out, .refresh_request_pin_oe_n);

  dia_colctr_model ext_counter (.reset_n, .enable(ext_en),
    .advance_pin(refresh_request_pin_in), .col_out(ext_col));

  always #50 clk_sys = ~clk_sys;

  task automatic wait_cycles(input int k);
    repeat (k) @(negedge clk_sys);
  endtask

  task automatic chk_addr(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t address %h not %h", $time, got, exp);
    end
  endtask

  task automatic chk_rows(input logic [3:0] got, input logic [3:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t row strobes %b not %b", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t signal %b not %b", $time, got, exp);
    end
  endtask

  task automatic final_report;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One generator period; noisy scrambles inputs the mode must ignore
  task automatic gen_fall(input logic noisy);
    column_strobe_in_n = 1'b0;
    if (noisy) begin
      row_col_select = 1'($urandom);
      row_strobe_in_n = 1'($urandom);
    end
    wait_cycles(6);
    column_strobe_in_n = 1'b1;
    wait_cycles(6);
  endtask

  task automatic set_mode(input logic [2:0] m);
    {refresh_mode_bit, mode_select_low} = m;
    wait_cycles(6);
  endtask

  // Loads the count select and clears the counter by pulling the pin
  task automatic set_count(input logic [1:0] sel);
    set_mode(MODE_EOC);
    {bank_select_high, bank_select_low} = sel;
    host_pull = 1'b1;
    address_latch_strobe = 1'b0;
    wait_cycles(6);
    address_latch_strobe = 1'b1;
    host_pull = 1'b0;
    wait_cycles(6);
    cnt = 0;
  endtask

  initial begin
    reset_n = 1'b0;
    {bank_select_high, bank_select_low, host_pull, ext_en} = 4'h0;
    {address_latch_strobe, chip_select_n, row_col_select, row_strobe_in_n,
     column_strobe_in_n, write_enable_in_n, refresh_mode_bit} = 7'h7f;
    mode_select_low = 2'h0;
    row_addr_in = 9'h000;
    col_host = 9'h000;
    void'($urandom(42122));
    wait_cycles(8);
    reset_n = 1'b1;
    wait_cycles(4);
    chk_bit(refresh_request_pin_oe_n, 1'b1);
    for (int s = 0; s < 3; s++) begin
      set_count(2'(s));
      eoc = eoc_tab[s];
      ext_en = 1'b1;
      set_mode(MODE_ALLBANK);
      for (int w = 0; w < eoc + 3; w++) begin
        gen_fall(1'b1);
        chk_rows(row_strobe_out_n, 4'h0);
        chk_addr(muxed_address_out, 9'(cnt));
        chk_bit(write_enable_out_n, 1'b0);
        gen_fall(1'b1);
        chk_bit(column_strobe_out_n, 1'b0);
        chk_addr(muxed_address_out, 9'(col_exp));
        gen_fall(1'b1);
        chk_rows(row_strobe_out_n, 4'hf);
        gen_fall(1'b1);
        cnt = (cnt == eoc) ? 0 : cnt + 1;
        if (cnt == 0) begin
          col_exp = (col_exp + 1) % 512;
        end
        chk_bit(refresh_request_pin_oe_n, 1'(cnt != eoc));
      end
      ext_en = 1'b0;
    end
    set_count(2'h3);
    {row_strobe_in_n, row_col_select} = 2'h3;
    set_mode(MODE_ALLBANK);
    row_strobe_in_n = 1'b0;
    col_host = 9'($urandom);
    wait_cycles(6);
    chk_rows(row_strobe_out_n, 4'h0);
    {row_col_select, column_strobe_in_n, write_enable_in_n} = 3'h0;
    wait_cycles(6);
    chk_addr(muxed_address_out, col_host);
    chk_bit(column_strobe_out_n, 1'b0);
    chk_bit(write_enable_out_n, 1'b0);
    {row_strobe_in_n, row_col_select, column_strobe_in_n,
     write_enable_in_n} = 4'hf;
    set_mode(MODE_EXT);
    for (int b = 0; b < 4; b++) begin
      {bank_select_high, bank_select_low} = 2'(b);
      row_addr_in = 9'($urandom);
      col_host = 9'($urandom);
      column_strobe_in_n = b[0] ? 1'b0 : 1'b1;
      chip_select_n = 1'b0;
      wait_cycles(6);
      chk_addr(muxed_address_out, row_addr_in);
      chk_bit(muxed_address_oe_n, 1'b0);
      row_strobe_in_n = 1'b0;
      wait_cycles(6);
      chk_rows(row_strobe_out_n, ~(4'h1 << b));
      row_col_select = 1'b0;
      wait_cycles(6);
      chk_addr(muxed_address_out, col_host);
      chk_bit(column_strobe_out_n, b[0] ? 1'b0 : 1'b1);
      column_strobe_in_n = 1'b0;
      wait_cycles(6);
      chk_bit(column_strobe_out_n, 1'b0);
      {row_strobe_in_n, column_strobe_in_n, row_col_select} = 3'h7;
      wait_cycles(6);
      chk_rows(row_strobe_out_n, 4'hf);
    end
    set_count(2'h3);
    {chip_select_n, row_col_select} = 2'h2;
    set_mode(MODE_AUTO);
    row_col_select = 1'b1;
    wait_cycles(6);
    row_strobe_in_n = 1'b0;
    wait_cycles(6);
    chk_rows(row_strobe_out_n, 4'h0);
    chk_addr(muxed_address_out, 9'(cnt));
    row_col_select = 1'b0;
    wait_cycles(6);
    chk_rows(row_strobe_out_n, 4'h0);
    row_strobe_in_n = 1'b1;
    cnt++;
    wait_cycles(8);
    chk_bit(refresh_request_pin_oe_n, 1'b1);
    set_mode(MODE_FORCED);
    repeat (3) gen_fall(1'b0);
    chk_rows(row_strobe_out_n, 4'hf);
    set_mode(MODE_AUTO);
    row_col_select = 1'b1;
    wait_cycles(6);
    row_col_select = 1'b0;
    wait_cycles(6);
    chk_bit(refresh_request_pin_oe_n, 1'b0);
    chk_bit(refresh_request_pin_out, 1'b0);
    set_mode(MODE_FORCED);
    n = 0;
    while (row_strobe_out_n !== 4'h0 && n < 3) begin
      gen_fall(1'b0);
      n++;
    end
    if (row_strobe_out_n !== 4'h0) begin
      errors++;
      $display("[FAIL] %0t forced refresh never began", $time);
      final_report();
    end
    chk_bit(1'(n <= 2), 1'b1);
    chk_bit(refresh_request_pin_oe_n, 1'b1);
    chk_addr(muxed_address_out, 9'(cnt));
    repeat (2) gen_fall(1'b0);
    chk_rows(row_strobe_out_n, 4'hf);
    cnt++;
    set_mode(MODE_AUTO);
    row_col_select = 1'b1;
    wait_cycles(6);
    row_strobe_in_n = 1'b0;
    wait_cycles(6);
    chk_addr(muxed_address_out, 9'(cnt));
    // Selected access in the automatic mode: one bank, timed column
    row_strobe_in_n = 1'b1;
    {bank_select_high, bank_select_low} = 2'h1;
    chip_select_n = 1'b0;
    wait_cycles(6);
    row_strobe_in_n = 1'b0;
    wait_cycles(6);
    chk_rows(row_strobe_out_n, 4'hd);
    chk_addr(muxed_address_out, col_host);
    chk_bit(column_strobe_out_n, 1'b0);
    final_report();
  end
endmodule
